// [common/shc_pkg.sv]
// Purpose: constants for the shading correction control registers
// Assumes: 32-bit register words, bit 0 of a field table is the word msb
// Notes: field positions below are word bit numbers (lsb = 0)
//
// Functional notes
// - correction applies only when enabled and an image is present.
// - correction image is shown only while enable and show bits are set.
// - a build is refused while a sixteen-bit output format is active.
// - read-only failure flag is set whenever a build could not produce an image.
// - software requests build; device holds busy, then clears busy and request.
// - a build averages the frame count given in the eight-bit field.
// - written frame count rounds to a power of two, limited by buffers.
// - a build uses the current resolution and video settings.
// - byte offset advances by the bytes moved after each buffer transfer.
// - save bit stores the image into the selected non-volatile slot.
// - load bit restores the image from the selected non-volatile slot.
// - erase bit erases the selected slot so it is not reloaded later.
// - after reset the device reloads a stored image without software.
// - save, load and erase report a four-bit result code.
// - info register reports slot total and largest image size.
// - bit 0 of each shading register flags the feature as present.
`default_nettype none
package shc_pkg;
	// register byte addresses
	localparam logic [31:0] ADDR_CTRL = 32'hf1000250;
	localparam logic [31:0] ADDR_MEM  = 32'hf1000254;
	localparam logic [31:0] ADDR_INFO = 32'hf1000258;
	// control word fields
	localparam int CTRL_PRES  = 31;
	localparam int CTRL_FAIL  = 30;
	localparam int CTRL_SHOW  = 27;
	localparam int CTRL_BUILD = 26;
	localparam int CTRL_ENA   = 25;
	localparam int CTRL_BUSY  = 24;
	localparam int CTRL_SAVE  = 23;
	localparam int CTRL_LOAD  = 22;
	localparam int CTRL_ERASE = 21;
	localparam int CTRL_ERR   = 12;
	localparam int CTRL_SLOT  = 8;
	localparam int CTRL_GRAB  = 0;
	// memory access word fields
	localparam int MEM_PRES = 31;
	localparam int MEM_WR   = 26;
	localparam int MEM_RD   = 25;
	localparam int MEM_POS  = 0;
	// info word fields
	localparam int INFO_PRES  = 31;
	localparam int INFO_TOTAL = 24;
	localparam int INFO_SIZE  = 0;
	// capabilities, arbitrary plain values
	localparam logic [3:0]  SLOT_TOTAL    = 4'h4;
	localparam logic [23:0] LARGEST_BYTES = 24'h100000;
	// reset values
	localparam logic [7:0]  GRAB_RESET = 8'h01;
	localparam logic [23:0] POS_RESET  = 24'h000000;
	// result codes
	localparam logic [3:0] ERR_NONE  = 4'h0;
	localparam logic [3:0] ERR_RANGE = 4'hf;
	// non-volatile commands
	typedef enum logic [1:0] {
		NV_SAVE  = 2'h0,
		NV_LOAD  = 2'h1,
		NV_ERASE = 2'h2,
		NV_BOOT  = 2'h3
	} shc_nv_cmd_type;
	// sequencer states
	typedef enum logic [3:0] {
		ST_BOOT      = 4'h1,
		ST_BOOT_WAIT = 4'h2,
		ST_IDLE      = 4'h4,
		ST_NV_WAIT   = 4'h8
	} shc_state_type;
endpackage
`default_nettype wire

// [hw/shc_ctrl.sv]
// Purpose: shading correction control, status and image access registers
// Assumes: build engine, flash controller and buffer share core_clk
// Notes: reads answer one cycle after the strobe, zero elsewhere
//
// The address-and-strobe port was decided locally.
`default_nettype none
module shc_ctrl
	import shc_pkg::*;
(
	// clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// register port
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// video path
	input  wire logic        format16_active,
	input  wire logic [7:0]  frames_avail_max,
	output logic             apply_correction,
	output logic             display_image,
	// build engine
	output logic             build_start,
	output logic      [7:0]  average_frame_count,
	output logic             build_poll_stall,
	input  wire logic        build_done,
	input  wire logic        build_ok,
	// flash controller
	output logic             nv_start,
	output shc_nv_cmd_type   nv_cmd,
	output logic      [3:0]  nv_slot,
	input  wire logic        nv_done,
	input  wire logic [3:0]  nv_status,
	// shared transfer buffer
	output logic             image_write_access,
	output logic             image_read_access,
	output logic      [23:0] buffer_byte_position,
	input  wire logic        xfer_done,
	input  wire logic [23:0] xfer_bytes
);
	logic rst_meta_reg, rst_sync_n;
	logic en_reg, en_next, show_reg, show_next;
	logic req_reg, req_next, busy_reg, busy_next;
	logic fail_reg, fail_next, present_reg, present_next;
	logic save_reg, save_next, load_reg, load_next;
	logic erase_reg, erase_next, wr_reg, wr_next, rd_reg, rd_next;
	logic [3:0]  err_reg, err_next, slot_reg, slot_next;
	logic [7:0]  grab_reg, grab_next, grab_rounded;
	logic [23:0] pos_reg, pos_next;
	logic [31:0] rdata_next;
	logic start_next, nvs_next, poll_next, apply_next, disp_next;
	logic [3:0]  nvslot_next;
	shc_nv_cmd_type nvcmd_next;
	shc_state_type  state_reg, state_next;
	logic wr_ctrl, wr_mem, nv_ask, nv_ok;
	logic [3:0] slot_w;

	// reset release through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n   <= rst_meta_reg;
		end
	end

	// frame count rounding
	shc_pow2_limit #(.WIDTH(8)) u_round (
		.value   (reg_wdata[CTRL_GRAB +: 8]),
		.limit   (frames_avail_max),
		.rounded (grab_rounded)
	);

	// write decode
	assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
	assign wr_mem  = reg_wr && (reg_addr == ADDR_MEM);
	assign slot_w  = reg_wdata[CTRL_SLOT +: 4];
	assign nv_ask  = wr_ctrl && (reg_wdata[CTRL_SAVE] ||
		reg_wdata[CTRL_LOAD] || reg_wdata[CTRL_ERASE]);
	assign nv_ok   = nv_status == ERR_NONE;

	// next state of all registers
	always_comb begin
		en_next = en_reg;
		show_next = show_reg;
		req_next = req_reg;
		busy_next = busy_reg;
		fail_next = fail_reg;
		present_next = present_reg;
		save_next = save_reg;
		load_next = load_reg;
		erase_next = erase_reg;
		err_next = err_reg;
		slot_next = slot_reg;
		grab_next = grab_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		pos_next = pos_reg;
		state_next = state_reg;
		start_next = 1'b0;
		nvs_next = 1'b0;
		nvcmd_next = nv_cmd;
		nvslot_next = nv_slot;
		rdata_next = 32'h00000000;
		// control register reads slow a running build
		poll_next = reg_rd && (reg_addr == ADDR_CTRL) && busy_reg;
		// build completion
		if (busy_reg && build_done) begin
			busy_next = 1'b0;
			req_next = 1'b0;
			fail_next = !build_ok;
			present_next = present_reg || build_ok;
		end
		// control write
		if (wr_ctrl) begin
			en_next = reg_wdata[CTRL_ENA];
			show_next = reg_wdata[CTRL_SHOW];
			slot_next = slot_w;
			grab_next = grab_rounded;
			if (reg_wdata[CTRL_BUILD] && !busy_reg) begin
				if (format16_active) begin
					fail_next = 1'b1;
				end else begin
					// engine samples current video settings
					req_next = 1'b1;
					busy_next = 1'b1;
					fail_next = 1'b0;
					start_next = 1'b1;
				end
			end
		end
		// non-volatile sequencing
		unique case (state_reg)
			ST_BOOT: begin
				nvs_next = 1'b1;
				nvcmd_next = NV_BOOT;
				state_next = ST_BOOT_WAIT;
			end
			ST_BOOT_WAIT: begin
				if (nv_done) begin
					present_next = present_reg || nv_ok;
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (nv_ask) begin
					if (slot_w >= SLOT_TOTAL) begin
						err_next = ERR_RANGE;
					end else begin
						nvs_next = 1'b1;
						nvslot_next = slot_w;
						state_next = ST_NV_WAIT;
						if (reg_wdata[CTRL_SAVE]) begin
							save_next = 1'b1;
							nvcmd_next = NV_SAVE;
						end else if (reg_wdata[CTRL_LOAD]) begin
							load_next = 1'b1;
							nvcmd_next = NV_LOAD;
						end else begin
							erase_next = 1'b1;
							nvcmd_next = NV_ERASE;
						end
					end
				end
			end
			ST_NV_WAIT: begin
				if (nv_done) begin
					err_next = nv_status;
					if (load_reg && nv_ok) begin
						present_next = 1'b1;
					end
					save_next = 1'b0;
					load_next = 1'b0;
					erase_next = 1'b0;
					state_next = ST_IDLE;
				end
			end
		endcase
		// buffer transfer moves the offset
		if (xfer_done && (wr_reg || rd_reg)) begin
			pos_next = 24'(pos_reg + xfer_bytes);
			if (wr_reg) begin
				present_next = 1'b1;
			end
		end
		// memory access write wins over the advance
		if (wr_mem) begin
			wr_next = reg_wdata[MEM_WR];
			rd_next = reg_wdata[MEM_RD];
			pos_next = reg_wdata[MEM_POS +: 24];
		end
		// read answer, lsb = 0 numbering
		if (reg_rd) begin
			if (reg_addr == ADDR_CTRL) begin
				rdata_next[CTRL_PRES] = 1'b1;
				rdata_next[CTRL_FAIL] = fail_reg;
				rdata_next[CTRL_SHOW] = show_reg;
				rdata_next[CTRL_BUILD] = req_reg;
				rdata_next[CTRL_ENA] = en_reg;
				rdata_next[CTRL_BUSY] = busy_reg;
				rdata_next[CTRL_SAVE] = save_reg;
				rdata_next[CTRL_LOAD] = load_reg;
				rdata_next[CTRL_ERASE] = erase_reg;
				rdata_next[CTRL_ERR +: 4] = err_reg;
				rdata_next[CTRL_SLOT +: 4] = slot_reg;
				rdata_next[CTRL_GRAB +: 8] = grab_reg;
			end else if (reg_addr == ADDR_MEM) begin
				rdata_next[MEM_PRES] = 1'b1;
				rdata_next[MEM_WR] = wr_reg;
				rdata_next[MEM_RD] = rd_reg;
				rdata_next[MEM_POS +: 24] = pos_reg;
			end else if (reg_addr == ADDR_INFO) begin
				rdata_next[INFO_PRES] = 1'b1;
				rdata_next[INFO_TOTAL +: 4] = SLOT_TOTAL;
				rdata_next[INFO_SIZE +: 24] = LARGEST_BYTES;
			end
		end
		apply_next = en_reg && present_reg;
		disp_next = en_reg && show_reg;
	end

	// register everything, frozen while clk_en is low
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			{en_reg, show_reg, req_reg, busy_reg} <= 4'h0;
			{fail_reg, present_reg, wr_reg, rd_reg} <= 4'h0;
			{save_reg, load_reg, erase_reg} <= 3'h0;
			err_reg <= ERR_NONE;
			slot_reg <= 4'h0;
			grab_reg <= GRAB_RESET;
			pos_reg <= POS_RESET;
			state_reg <= ST_BOOT;
			reg_rdata <= 32'h00000000;
			build_start <= 1'b0;
			build_poll_stall <= 1'b0;
			nv_start <= 1'b0;
			nv_cmd <= NV_SAVE;
			nv_slot <= 4'h0;
			apply_correction <= 1'b0;
			display_image <= 1'b0;
		end else if (clk_en) begin
			en_reg <= en_next;
			show_reg <= show_next;
			req_reg <= req_next;
			busy_reg <= busy_next;
			fail_reg <= fail_next;
			present_reg <= present_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			save_reg <= save_next;
			load_reg <= load_next;
			erase_reg <= erase_next;
			err_reg <= err_next;
			slot_reg <= slot_next;
			grab_reg <= grab_next;
			pos_reg <= pos_next;
			state_reg <= state_next;
			reg_rdata <= rdata_next;
			build_start <= start_next;
			build_poll_stall <= poll_next;
			nv_start <= nvs_next;
			nv_cmd <= nvcmd_next;
			nv_slot <= nvslot_next;
			apply_correction <= apply_next;
			display_image <= disp_next;
		end
	end

	// register mirrors toward the outside
	assign average_frame_count = grab_reg;
	assign image_write_access = wr_reg;
	assign image_read_access = rd_reg;
	assign buffer_byte_position = pos_reg;

	// checks on the register behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_n);

	sequence s_build_ask;
		clk_en && wr_ctrl && reg_wdata[CTRL_BUILD] && !busy_reg;
	endsequence
	sequence s_build_go;
		s_build_ask and (!format16_active);
	endsequence

	a_apply_gate: assert property (
		clk_en |=> apply_correction ==
			($past(en_reg) && $past(present_reg)))
		else $error("correction gate wrong");
	a_display_gate: assert property (
		clk_en |=> display_image ==
			($past(en_reg) && $past(show_reg)))
		else $error("image display gate wrong");
	a_fmt16_refuse: assert property (
		s_build_ask and format16_active
		|=> !busy_reg && fail_reg && !build_start)
		else $error("build not refused");
	a_build_begin: assert property (
		s_build_go |=> build_start && busy_reg && req_reg && !fail_reg)
		else $error("build did not start");
	a_build_end: assert property (
		clk_en && busy_reg && build_done
		|=> !busy_reg && !req_reg && (fail_reg == !$past(build_ok)))
		else $error("build end wrong");
	a_grab_onehot: assert property (
		$onehot(grab_reg))
		else $error("frame count not a power of two");
	a_pos_advance: assert property (
		clk_en && xfer_done && (wr_reg || rd_reg) && !wr_mem
		|=> pos_reg == 24'($past(pos_reg) + $past(xfer_bytes)))
		else $error("offset did not advance");
	a_slot_range: assert property (
		clk_en && nv_ask && state_reg == ST_IDLE && slot_w >= SLOT_TOTAL
		|=> err_reg == ERR_RANGE && !nv_start)
		else $error("range error not reported");
	a_boot_reload: assert property (
		clk_en && state_reg == ST_BOOT
		|=> nv_start && nv_cmd == NV_BOOT && state_reg == ST_BOOT_WAIT)
		else $error("no reload after reset");
endmodule // shc_ctrl
`default_nettype wire

// [hw/shc_pow2_limit.sv]
// Purpose: round a frame count down to a power of two under a limit
// Assumes: a zero value or zero limit yields one
// Notes: purely combinational
`default_nettype none
module shc_pow2_limit #(
	parameter int WIDTH = 8
) (
	// count in and limit
	input  wire logic [WIDTH-1:0] value,
	input  wire logic [WIDTH-1:0] limit,
	// rounded count
	output logic      [WIDTH-1:0] rounded
);
	// clamp then keep the highest set bit
	always_comb begin
		logic [WIDTH-1:0] v;
		v = (value > limit) ? limit : value;
		rounded = WIDTH'(1);
		for (int i = 0; i < WIDTH; i++) begin
			if (v[i]) begin
				rounded = WIDTH'(1) << i;
			end
		end
	end
endmodule // shc_pow2_limit
`default_nettype wire

// [verification/tb.sv]
// Purpose: self-checking bench for the shading control registers
// Assumes: one clock domain, clk_en low only in the freeze check
// Notes: reads queue their expected word, a monitor compares them
`default_nettype none
module tb
	import shc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// design inputs
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [31:0] reg_addr = 32'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        format16_active = 1'b0;
	logic [7:0]  frames_avail_max = 8'h20;
	logic        build_done = 1'b0;
	logic        build_ok = 1'b0;
	logic        nv_done = 1'b0;
	logic [3:0]  nv_status = 4'h0;
	logic        xfer_done = 1'b0;
	logic [23:0] xfer_bytes = 24'h0;
	logic        clk_en = 1'b1;
	// design outputs
	logic [31:0]    reg_rdata;
	logic           apply_correction;
	logic           display_image;
	logic           build_start;
	logic [7:0]     average_frame_count;
	logic           build_poll_stall;
	logic           nv_start;
	shc_nv_cmd_type nv_cmd;
	logic [3:0]     nv_slot;
	logic           image_write_access;
	logic           image_read_access;
	logic [23:0]    buffer_byte_position;
	// bench state and shadow of the control word
	logic [31:0]    exp_q[$];
	logic           rd_pend = 1'b0;
	int             n_errors = 0;
	int             cmp_count = 0;
	int             n_bs = 0;
	int             n_nv = 0;
	int             n_stall = 0;
	int             exp_bs = 0;
	shc_nv_cmd_type last_cmd;
	logic [3:0]     last_slot;
	logic           ena, show, fail;
	logic [3:0]     slot, err;
	logic [7:0]     grab;
	logic [1:0]     acc;
	logic [23:0]    pos = 24'h0;
	logic [15:0]    lf = 16'h5ab2; // seed 23218

	shc_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.format16_active(format16_active),
		.frames_avail_max(frames_avail_max),
		.apply_correction(apply_correction), .display_image(display_image),
		.build_start(build_start), .average_frame_count(average_frame_count),
		.build_poll_stall(build_poll_stall), .build_done(build_done),
		.build_ok(build_ok), .nv_start(nv_start), .nv_cmd(nv_cmd),
		.nv_slot(nv_slot), .nv_done(nv_done), .nv_status(nv_status),
		.image_write_access(image_write_access),
		.image_read_access(image_read_access),
		.buffer_byte_position(buffer_byte_position),
		.xfer_done(xfer_done), .xfer_bytes(xfer_bytes));

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// clamp to the ceiling, round down to a power of two, zero gives one
	function automatic logic [7:0] round_cnt(input logic [7:0] v, lim);
		logic [7:0] c;
		c = (v > lim) ? lim : v;
		for (int b = 7; b >= 0; b--)
			if (c[b])
				return 8'h01 << b;
		return 8'h01;
	endfunction

	function automatic logic [31:0] ctrl_word(input logic bld, busy,
		input logic [2:0] nvb);
		return {1'b1, fail, 2'h0, show, bld, ena, busy, nvb, 5'h00, err,
			slot, grab};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus_wr(input logic [31:0] a, d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [31:0] a, e);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic ctrl_wr(input logic bld, input logic [2:0] nvb,
		input logic [7:0] raw);
		grab = round_cnt(raw, frames_avail_max);
		bus_wr(ADDR_CTRL, {4'h0, show, bld, ena, 1'b0, nvb, 9'h000, slot, raw});
	endtask

	// one-cycle pulse: 0 build done, 1 flash done, 2 buffer transfer
	task automatic pulse_in(input int k, input logic [23:0] v);
		@(posedge core_clk);
		build_ok   <= v[0];
		nv_status  <= v[3:0];
		xfer_bytes <= v;
		build_done <= (k == 0);
		nv_done    <= (k == 1);
		xfer_done  <= (k == 2);
		@(posedge core_clk);
		build_done <= 1'b0;
		nv_done    <= 1'b0;
		xfer_done  <= 1'b0;
	endtask

	task automatic settle();
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	task automatic do_reset(input logic [3:0] boot_st);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		{ena, show, fail, slot, err} = 11'h000;
		grab = GRAB_RESET;
		n_nv = 0;
		for (int i = 0; i < 12 && n_nv == 0; i++)
			@(posedge core_clk);
		chk("boot_seen", 32'h1, n_nv); // reload without software
		chk("boot_cmd", NV_BOOT, last_cmd); // reload command
		pulse_in(1, {20'h0, boot_st});
	endtask

	task automatic end_of_test();
		$display("errors %0d, comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// read data compare, one cycle after each read strobe
	always @(posedge core_clk) begin
		if (rd_pend)
			chk("reg_rdata", exp_q.pop_front(), reg_rdata);
		else if (rst_n)
			chk("rdata_idle", 32'h0, reg_rdata); // zero between reads
		rd_pend <= reg_rd;
	end

	// pulse tally, sampled mid-cycle
	always @(negedge core_clk) begin
		if (build_start)
			n_bs++;
		if (build_poll_stall)
			n_stall++;
		if (nv_start) begin
			n_nv++;
			last_cmd  = nv_cmd;
			last_slot = nv_slot;
		end
	end

	// watchdog
	initial begin
		repeat (6000) @(posedge core_clk);
		n_errors++;
		end_of_test();
	end

	// main sequence
	initial begin
		do_reset(4'h1);
		bus_rd(ADDR_INFO, {1'b1, 3'h0, SLOT_TOTAL, LARGEST_BYTES});
		bus_rd(ADDR_MEM, {1'b1, 7'h00, POS_RESET}); // presence bit
		bus_rd(ADDR_CTRL, ctrl_word(1'b0, 1'b0, 3'h0)); // presence bit
		bus_rd(ADDR_INFO + 32'h4, 32'h0); // unmapped reads zero
		ena = 1'b1;
		ctrl_wr(1'b0, 3'h0, 8'h01);
		settle();
		chk("apply", 1'b0, apply_correction); // no image yet
		@(posedge core_clk);
		format16_active <= 1'b1;
		fail = 1'b1;
		ctrl_wr(1'b1, 3'h0, 8'h01);
		bus_rd(ADDR_CTRL, ctrl_word(1'b0, 1'b0, 3'h0)); // refused
		chk("build_start", exp_bs, n_bs); // refused
		@(posedge core_clk);
		format16_active <= 1'b0;
		// failing build, then a good one
		for (int i = 0; i < 2; i++) begin
			lf = lfsr(lf);
			@(posedge core_clk);
			frames_avail_max <= lf[15:8];
			@(posedge core_clk);
			fail = 1'b0;
			ctrl_wr(1'b1, 3'h0, lf[7:0]);
			exp_bs++;
			bus_rd(ADDR_CTRL, ctrl_word(1'b1, 1'b1, 3'h0)); // busy
			ctrl_wr(1'b1, 3'h0, lf[7:0]); // ignored while busy
			pulse_in(0, {23'h0, i[0]});
			fail = !i[0];
			bus_rd(ADDR_CTRL, ctrl_word(1'b0, 1'b0, 3'h0));
			chk("frame_count", grab, average_frame_count);
			chk("build_start", exp_bs, n_bs); // one start
			chk("poll_stall", exp_bs, n_stall); // busy poll seen
		end
		// enable and show combinations
		for (int i = 0; i < 4; i++) begin
			{ena, show} = i[1:0];
			ctrl_wr(1'b0, 3'h0, 8'h01);
			settle();
			chk("apply", ena, apply_correction); // image present
			chk("display", ena & show, display_image); // both bits
		end
		@(posedge core_clk);
		do_reset(4'h0);
		ena = 1'b1;
		ctrl_wr(1'b0, 3'h0, 8'h01);
		settle();
		chk("apply", 1'b1, apply_correction); // reloaded image
		// save, load, erase with result codes 0 to 5
		for (int i = 0; i < 6; i++) begin
			lf = lfsr(lf);
			slot = {2'h0, lf[1:0]};
			ctrl_wr(1'b0, 3'h4 >> (i % 3), 8'h01); // save, load, erase in turn
			bus_rd(ADDR_CTRL, ctrl_word(1'b0, 1'b0, 3'h4 >> (i % 3)));
			chk("nv_cmd", i % 3, last_cmd); // command kind
			chk("nv_slot", slot, last_slot); // chosen slot
			ctrl_wr(1'b0, 3'h1, 8'h01); // ignored while pending
			pulse_in(1, 24'(i));
			err = 4'(i);
			bus_rd(ADDR_CTRL, ctrl_word(1'b0, 1'b0, 3'h0)); // code
		end
		slot = 4'h4 | lf[3:0];
		ctrl_wr(1'b0, 3'h2, 8'h01);
		err = ERR_RANGE;
		bus_rd(ADDR_CTRL, ctrl_word(1'b0, 1'b0, 3'h0)); // bad slot
		chk("nv_starts", 32'h7, n_nv); // no flash access
		// image transfers: write access, read access, then none
		for (int i = 0; i < 5; i++) begin
			lf = lfsr(lf);
			if (i == 0 || i > 2) begin
				acc = (i == 0) ? 2'h2 : (i == 3) ? 2'h1 : 2'h0;
				if (i == 3)
					pos = 24'h0;
				bus_wr(ADDR_MEM, {5'h00, acc, 1'b0, pos});
			end
			if (i == 2) begin
				@(posedge core_clk);
				clk_en <= 1'b0; // frozen: this transfer is lost
			end
			pulse_in(2, {14'h0, lf[9:0]});
			clk_en <= 1'b1;
			if (acc != 2'h0 && i != 2)
				pos = pos + {14'h0, lf[9:0]};
			bus_rd(ADDR_MEM, {1'b1, 4'h0, acc, 1'b0, pos});
			chk("position", pos, buffer_byte_position); // advance
			chk("access", acc, {image_write_access, image_read_access});
		end
		end_of_test();
	end
endmodule // tb
`default_nettype wire
